// file: pkg/ifctl_pkg.sv
// constants, states and state records of the if control-board logic
// assumes one 100 mhz clock; everything else is derived from it here
package ifctl_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // clocking: the processor bus steps at the nominal processor rate
  localparam int SYS_CLK_KHZ = 100000;
  localparam int CPU_CLK_KHZ = 5000;
  localparam int TICK_CYCLES = SYS_CLK_KHZ / CPU_CLK_KHZ;
  localparam int TICK_W = 5;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // program memory and bus constants
  localparam int ROM_AW = 11;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [7:0] BUS_IDLE = 8'hff;
  localparam int DET_SEL_LINE = 3;
  localparam logic [2:0] IFC_DATA_REG = 3'h0;
  localparam logic [2:0] IFC_ADDR_REG = 3'h1;
  localparam logic [3:0] LATCH_RST = 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // control latch select table: two low address lines and a data nibble each
  // 0 cal atten, 1 lc bypass, 2-3 video bw, 4-5 crystal bw, 6-7 lc bw, 8 xtal bypass
  localparam int NUM_LATCH = 9;
  localparam int LAT_LINE_A [NUM_LATCH] = '{1, 0, 2, 2, 2, 2, 1, 1, 0};
  localparam int LAT_LINE_B [NUM_LATCH] = '{6, 6, 6, 6, 7, 7, 7, 7, 7};
  localparam bit LAT_HI [NUM_LATCH] = '{1, 0, 0, 0, 1, 1, 1, 1, 0};

  //////////////////////////////////////////////////////////////////////////////
  // bus commands and sequencer states
  typedef enum logic [1:0] {OP_FETCH, OP_WRITE, OP_RD_DET, OP_LAMPS} bus_op_e;
  typedef enum logic [3:0] {
    ST_PU_SW, ST_PU_WR, ST_PU_END, ST_IDLE, ST_ALE, ST_ADDR, ST_STROBE,
    ST_IFC_SEL, ST_IFC_RD, ST_IFC_END
  } bus_st_e;

  // whole sequencer state
  typedef struct packed {
    bus_st_e st;
    bus_op_e op;
    logic [TICK_W-1:0] cnt;
    logic ready;
    logic ale;
    logic psen_n;
    logic wr_n;
    logic rd_n;
    logic drive;
    logic [7:0] dout;
    logic [7:0] wdat;
    logic [7:0] alat;
    logic [2:0] addr_hi;
    logic [10:0] pc;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic msg_valid;
    logic [7:0] msg_data;
    logic [2:0] ifc_addr;
    logic ifc_cs_n;
    logic ifc_rd_n;
    logic ifc_wr_n;
    logic ifc_oe;
    logic [7:0] ifc_dout;
    logic sw_en;
    logic [7:0] mod_addr;
    logic lamp_err;
    logic lamp_act;
  } ctl_s;

  localparam ctl_s CTL_RST = '{st: ST_PU_SW, op: OP_FETCH, cnt: '0, ready: 1'b0,
    ale: 1'b0, psen_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, drive: 1'b0, dout: 8'h00,
    wdat: 8'h00, alat: 8'h00, addr_hi: 3'h0, pc: PC_RESET, rsp_valid: 1'b0,
    rsp_data: 8'h00, msg_valid: 1'b0, msg_data: 8'h00, ifc_addr: 3'h0,
    ifc_cs_n: 1'b1, ifc_rd_n: 1'b1, ifc_wr_n: 1'b1, ifc_oe: 1'b0,
    ifc_dout: 8'h00, sw_en: 1'b0, mod_addr: 8'h00, lamp_err: 1'b0, lamp_act: 1'b0};

  // one control latch
  typedef struct packed {
    logic [3:0] val;
  } latch_s;

endpackage

// file: hw/program_rom.sv
// program memory: 2k by 8, registered read, loadable image port
// assumes the loader and the reader never use the same cycle for one word
`timescale 1ns/100ps
module program_rom
  import ifctl_pkg::*;
#(
  parameter int AW = ROM_AW,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // fetch side
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  output logic [DW-1:0] rdata,
  // image load side
  input wire logic ld_en,
  input wire logic [AW-1:0] ld_addr,
  input wire logic [DW-1:0] ld_data
);

  logic [DW-1:0] mem [2**AW];

  // read data come out of a register, as a real rom access would
  always_ff @(posedge clk) begin
    if (ld_en) begin
      mem[ld_addr] <= ld_data;
    end
    if (rd_en) begin
      rdata <= mem[addr];
    end
  end

endmodule

// file: hw/control_latch.sv
// one four-bit write-only control latch selected by two low address lines
// assumes wr_rise is a one-cycle pulse on the write strobe's rising edge
`timescale 1ns/100ps
module control_latch
  import ifctl_pkg::*;
#(
  parameter int LINE_A = 0,
  parameter int LINE_B = 6,
  parameter bit HI_NIB = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // processor bus
  input wire logic wr_rise,
  input wire logic [7:0] addr,
  input wire logic [7:0] data,
  // latch outputs
  output logic [3:0] q
);

  latch_s s_q;
  latch_s s_d;
  logic sel;
  logic [3:0] nib;

  // both lines low select this latch; the nibble is fixed by wiring
  assign sel = !addr[LINE_A] && !addr[LINE_B];
  assign nib = HI_NIB ? data[7:4] : data[3:0];
  assign q = s_q.val;

  // load only on a selected write edge, hold otherwise
  always_comb begin
    s_d = s_q;
    if (wr_rise && sel) begin
      s_d.val = nib;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '{val: LATCH_RST};
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_load;
    @(posedge clk) disable iff (!reset_n) wr_rise && sel |=> q == $past(nib);
  endproperty
  a_load: assert property (p_load) else $error("latch missed a selected write");

  property p_hold;
    @(posedge clk) disable iff (!reset_n) !(wr_rise && sel) |=> $stable(q);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without select");

endmodule

// file: hw/if_control_latch_decode.sv
// processor-side control logic of the if control board: bus sequencer,
// address latch, program fetch, control latches, detector read, interface
// chip service, power-up address load and panel lamps
// assumes all inputs are synchronous to clk; one core issues bus commands
`timescale 1ns/100ps
module if_control_latch_decode
  import ifctl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus commands from the processor core
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [10:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // serial-bus interface chip
  input wire logic service_request_n,
  input wire logic sys_reset_n,
  input wire logic [7:0] ifc_data_i,
  output logic [7:0] ifc_data_o,
  output logic ifc_data_oe,
  output logic [2:0] ifc_addr,
  output logic ifc_cs_n,
  output logic ifc_rd_n,
  output logic ifc_wr_n,
  output logic msg_valid,
  output logic [7:0] msg_data,
  // module address switch
  input wire logic [7:0] module_address_switch,
  output logic addr_sw_en,
  // level detectors, low when the signal is too low
  input wire logic [1:0] det_level_n,
  // program memory image load
  input wire logic rom_ld_en,
  input wire logic [10:0] rom_ld_addr,
  input wire logic [7:0] rom_ld_data,
  // front panel lamps
  output logic lamp_error,
  output logic lamp_active,
  // control latch outputs
  output logic [3:0] cal_attenuator_steps,
  output logic [3:0] lc_stage_bypass,
  output logic [7:0] video_bandwidth_select,
  output logic [7:0] crystal_bandwidth_code,
  output logic [7:0] lc_bandwidth_code,
  output logic [3:0] crystal_stage_bypass
);

  ctl_s s_q;
  ctl_s s_d;
  logic tick;
  logic take;
  logic wr_rise;
  logic [7:0] ad_bus;
  logic [7:0] rom_rdata;
  logic [10:0] rom_addr;
  logic [3:0] lat_q [NUM_LATCH];

  //////////////////////////////////////////////////////////////////////////////
  // rate divider: one enable pulse per processor clock period
  assign tick = s_q.cnt == TICK_LAST;
  assign take = cmd_valid && s_q.ready;
  assign rom_addr = {s_q.addr_hi, s_q.alat};

  // shared address/data bus; the detector buffer only drives during its read
  always_comb begin
    if (s_q.drive) begin
      ad_bus = s_q.dout;
    end else if (!s_q.psen_n) begin
      ad_bus = rom_rdata;
    end else if (!s_q.rd_n && !s_q.alat[DET_SEL_LINE]) begin
      ad_bus = {6'h3f, det_level_n};
    end else begin
      ad_bus = BUS_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus sequencer: every phase ends on a tick, so the first phase of a cycle lasts 1 to 20 cycles
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.msg_valid = 1'b0;
    s_d.cnt = tick ? '0 : s_q.cnt + 5'h01;
    case (s_q.st)
      ST_PU_SW: begin
        s_d.sw_en = 1'b1;
        if (tick) begin
          s_d.mod_addr = module_address_switch;
          s_d.ifc_dout = module_address_switch;
          s_d.ifc_addr = IFC_ADDR_REG;
          s_d.ifc_cs_n = 1'b0;
          s_d.ifc_wr_n = 1'b0;
          s_d.ifc_oe = 1'b1;
          s_d.st = ST_PU_WR;
        end
      end
      ST_PU_WR: begin
        if (tick) begin
          s_d.ifc_wr_n = 1'b1;
          s_d.st = ST_PU_END;
        end
      end
      ST_PU_END: begin
        if (tick) begin
          s_d.ifc_cs_n = 1'b1;
          s_d.ifc_oe = 1'b0;
          s_d.sw_en = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          s_d.op = bus_op_e'(cmd_op);
          s_d.wdat = cmd_data;
          if (bus_op_e'(cmd_op) == OP_LAMPS) begin
            s_d.lamp_err = cmd_data[0];
            s_d.lamp_act = cmd_data[1];
          end else begin
            // fetches use the program pointer, other cycles the given address
            s_d.ale = 1'b1;
            s_d.drive = 1'b1;
            s_d.dout = (bus_op_e'(cmd_op) == OP_FETCH) ? s_q.pc[7:0] : cmd_addr[7:0];
            s_d.addr_hi = (bus_op_e'(cmd_op) == OP_FETCH) ? s_q.pc[10:8] : cmd_addr[10:8];
            s_d.st = ST_ALE;
          end
        end else if (!service_request_n && sys_reset_n) begin
          // suspend: pending commands wait, the pointer is kept for resuming
          s_d.ifc_addr = IFC_DATA_REG;
          s_d.ifc_cs_n = 1'b0;
          s_d.st = ST_IFC_SEL;
        end
      end
      ST_ALE: begin
        if (tick) begin
          s_d.ale = 1'b0;
          s_d.drive = s_q.op == OP_WRITE;
          s_d.dout = s_q.wdat;
          s_d.st = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (tick) begin
          s_d.psen_n = s_q.op != OP_FETCH;
          s_d.wr_n = s_q.op != OP_WRITE;
          s_d.rd_n = s_q.op != OP_RD_DET;
          s_d.st = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tick) begin
          s_d.psen_n = 1'b1;
          s_d.wr_n = 1'b1;
          s_d.rd_n = 1'b1;
          s_d.drive = 1'b0;
          s_d.rsp_valid = s_q.op != OP_WRITE;
          s_d.rsp_data = ad_bus;
          if (s_q.op == OP_FETCH) begin
            s_d.pc = s_q.pc + 11'h001;
          end
          s_d.st = ST_IDLE;
        end
      end
      ST_IFC_SEL: begin
        if (tick) begin
          s_d.ifc_rd_n = 1'b0;
          s_d.st = ST_IFC_RD;
        end
      end
      ST_IFC_RD: begin
        if (tick) begin
          s_d.ifc_rd_n = 1'b1;
          s_d.msg_valid = 1'b1;
          s_d.msg_data = ifc_data_i;
          s_d.st = ST_IFC_END;
        end
      end
      ST_IFC_END: begin
        if (tick) begin
          s_d.ifc_cs_n = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // reset line from the system: drop any service read, restart the pointer
    if (!sys_reset_n) begin
      s_d.pc = PC_RESET;
      if (s_q.st == ST_IFC_SEL || s_q.st == ST_IFC_RD || s_q.st == ST_IFC_END) begin
        s_d.ifc_cs_n = 1'b1;
        s_d.ifc_rd_n = 1'b1;
        s_d.msg_valid = 1'b0;
        s_d.st = ST_IDLE;
      end
    end
    // the low byte is caught as the latch strobe falls
    if (s_q.ale && !s_d.ale) begin
      s_d.alat = ad_bus;
    end
    s_d.ready = s_d.st == ST_IDLE && service_request_n && sys_reset_n;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= CTL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // latches load as the write strobe rises, with address and data still held
  assign wr_rise = !s_q.wr_n && s_d.wr_n;

  //////////////////////////////////////////////////////////////////////////////
  // program memory and control latches
  program_rom #(.AW(ROM_AW), .DW(8)) u_rom (
    .clk(clk),
    .rd_en(!s_q.psen_n),
    .addr(rom_addr),
    .rdata(rom_rdata),
    .ld_en(rom_ld_en),
    .ld_addr(rom_ld_addr),
    .ld_data(rom_ld_data)
  );

  for (genvar i = 0; i < NUM_LATCH; i++) begin : g_latch
    control_latch #(.LINE_A(LAT_LINE_A[i]), .LINE_B(LAT_LINE_B[i]), .HI_NIB(LAT_HI[i])) u_lat (
      .clk(clk),
      .reset_n(reset_n),
      .wr_rise(wr_rise),
      .addr(s_q.alat),
      .data(ad_bus),
      .q(lat_q[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign cmd_ready = s_q.ready;
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_data = s_q.rsp_data;
  assign ifc_data_o = s_q.ifc_dout;
  assign ifc_data_oe = s_q.ifc_oe;
  assign ifc_addr = s_q.ifc_addr;
  assign ifc_cs_n = s_q.ifc_cs_n;
  assign ifc_rd_n = s_q.ifc_rd_n;
  assign ifc_wr_n = s_q.ifc_wr_n;
  assign msg_valid = s_q.msg_valid;
  assign msg_data = s_q.msg_data;
  assign addr_sw_en = s_q.sw_en;
  assign lamp_error = s_q.lamp_err;
  assign lamp_active = s_q.lamp_act;
  assign cal_attenuator_steps = lat_q[0];
  assign lc_stage_bypass = lat_q[1];
  assign video_bandwidth_select = {lat_q[3], lat_q[2]};
  assign crystal_bandwidth_code = {lat_q[5], lat_q[4]};
  assign lc_bandwidth_code = {lat_q[7], lat_q[6]};
  assign crystal_stage_bypass = lat_q[8];

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_alat;
    $fell(s_q.ale) |-> s_q.alat == $past(ad_bus);
  endproperty
  a_alat: assert property (p_alat) else $error("address byte not latched");

  property p_fetch_addr;
    !s_q.psen_n |-> rom_addr == s_q.pc;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");

  property p_fetch_data;
    $rose(s_q.psen_n) |-> s_q.rsp_valid && s_q.rsp_data == $past(rom_rdata);
  endproperty
  a_fetch_data: assert property (p_fetch_data) else $error("instruction not taken");

  property p_irq_enter;
    s_q.st == ST_IDLE && !take && !service_request_n && sys_reset_n |=>
      s_q.st == ST_IFC_SEL && !s_q.ifc_cs_n && !s_q.ready;
  endproperty
  a_irq_enter: assert property (p_irq_enter) else $error("request not serviced");

  property p_sys_reset;
    !sys_reset_n |=> s_q.pc == PC_RESET && s_q.ifc_rd_n && !s_q.ready;
  endproperty
  a_sys_reset: assert property (p_sys_reset) else $error("reset line ignored");

  property p_powerup;
    s_q.st == ST_PU_WR |-> s_q.sw_en && !s_q.ifc_wr_n && s_q.ifc_dout == s_q.mod_addr;
  endproperty
  a_powerup: assert property (p_powerup) else $error("module address not sent");

  property p_det_read;
    s_q.rsp_valid && s_q.op == OP_RD_DET && !s_q.alat[DET_SEL_LINE] |->
      s_q.rsp_data[1:0] == $past(det_level_n);
  endproperty
  a_det_read: assert property (p_det_read) else $error("detector levels lost");

  property p_rate;
    tick |=> !tick [*8];
  endproperty
  a_rate: assert property (p_rate) else $error("bus step too fast");

  property p_lamps;
    take && s_q.st == ST_IDLE && cmd_op == OP_LAMPS |=>
      lamp_error == $past(cmd_data[0]) && lamp_active == $past(cmd_data[1]);
  endproperty
  a_lamps: assert property (p_lamps) else $error("lamp drive not updated");

  property p_irq_read;
    $fell(s_q.ifc_rd_n) |-> !s_q.ifc_cs_n && s_q.ifc_addr == IFC_DATA_REG ##1
      (s_q.ifc_rd_n == 1'b0) [*8];
  endproperty
  a_irq_read: assert property (p_irq_read) else $error("service read malformed");

  c_fetch: cover property ($rose(s_q.psen_n));
  c_write: cover property (wr_rise);
  c_service: cover property (s_q.msg_valid);
  c_sys_reset: cover property (!sys_reset_n && s_q.st == ST_IFC_RD);

endmodule

// file: verif/ifc_chip_model.sv
// model of the serial-bus interface chip on the far side of the block
// assumes the design's registered chip strobes and one shared clock
`timescale 1ns/100ps
module ifc_chip_model
  import ifctl_pkg::*;
(
  // clock
  input wire logic clk,
  // chip bus from the design
  input wire logic ifc_cs_n,
  input wire logic ifc_rd_n,
  input wire logic ifc_wr_n,
  input wire logic [2:0] ifc_addr,
  input wire logic [7:0] ifc_data_o,
  input wire logic ifc_data_oe,
  output logic [7:0] ifc_data_i,
  output logic service_request_n,
  // bench side
  input wire logic msg_load,
  input wire logic [7:0] msg_byte,
  output logic [7:0] got_addr
);
  ////////////////////////////////////////////////////////////
  logic pend_q = 1'b0;
  logic rd_q = 1'b1;
  logic wr_q = 1'b1;
  logic [7:0] msg_q = 8'h00;

  // request stays low until a data read strobe has ended
  assign service_request_n = ~pend_q;
  // a released bus shows the inverse, so a stale byte never passes
  assign ifc_data_i = (!ifc_cs_n && !ifc_rd_n && ifc_addr == IFC_DATA_REG) ? msg_q
    : ~msg_q;

  // strobe edges seen one cycle late, like a real sampling chip
  always_ff @(posedge clk) begin
    rd_q <= ifc_rd_n;
    wr_q <= ifc_wr_n;
    if (msg_load) begin
      pend_q <= 1'b1;
      msg_q <= msg_byte;
    end else if (ifc_rd_n && !rd_q && !ifc_cs_n) begin
      pend_q <= 1'b0;
    end
    if (ifc_wr_n && !wr_q && !ifc_cs_n && ifc_data_oe && ifc_addr == IFC_ADDR_REG) begin
      got_addr <= ifc_data_o;
    end
  end
endmodule

// file: verif/tb_if_control_latch_decode.sv
// self-checking bench of the if control-board logic
// assumes the command port contract and a 100 mhz clock
`timescale 1ns/100ps
module tb_if_control_latch_decode import ifctl_pkg::*;;
  logic clk, reset_n, cmd_valid, cmd_ready, rsp_valid, service_request_n, sys_reset_n;
  logic ifc_data_oe, ifc_cs_n, ifc_rd_n, ifc_wr_n, msg_valid, addr_sw_en, rom_ld_en;
  logic lamp_error, lamp_active, msg_load;
  logic [1:0] cmd_op, det_level_n;
  logic [2:0] ifc_addr;
  logic [3:0] cal_attenuator_steps, lc_stage_bypass, crystal_stage_bypass;
  logic [3:0] e_cal, e_lcb, e_xsb;
  logic [10:0] cmd_addr, rom_ld_addr;
  logic [7:0] cmd_data, rsp_data, ifc_data_i, ifc_data_o, msg_data, module_address_switch;
  logic [7:0] rom_ld_data, video_bandwidth_select, crystal_bandwidth_code, lc_bandwidth_code;
  logic [7:0] msg_byte, got_addr, e_vid, e_xbw, e_lbw;
  int err_count = 0;
  int tests_run = 0;
  int lat;
  // the first six addresses each have only one latch pair low; then two with none, then all
  localparam logic [7:0] WA [9] = '{8'hbd, 8'hbe, 8'hbb, 8'h7b, 8'h7d, 8'h7e, 8'hff,
    8'h3f, 8'h00};
  localparam logic [7:0] WD [9] = '{8'h1e, 8'h2d, 8'h3c, 8'h4b, 8'h5a, 8'h69, 8'h78,
    8'h87, 8'ha5};

  // switch floats to the inverse while its enable is off
  assign module_address_switch = addr_sw_en ? 8'h2b : 8'hd4;

  if_control_latch_decode dut (.clk, .reset_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data,
    .cmd_ready, .rsp_valid, .rsp_data, .service_request_n, .sys_reset_n, .ifc_data_i,
    .ifc_data_o, .ifc_data_oe, .ifc_addr, .ifc_cs_n, .ifc_rd_n, .ifc_wr_n, .msg_valid,
    .msg_data, .module_address_switch, .addr_sw_en, .det_level_n, .rom_ld_en,
    .rom_ld_addr, .rom_ld_data, .lamp_error, .lamp_active, .cal_attenuator_steps,
    .lc_stage_bypass, .video_bandwidth_select, .crystal_bandwidth_code,
    .lc_bandwidth_code, .crystal_stage_bypass);

  ifc_chip_model chip (.clk, .ifc_cs_n, .ifc_rd_n, .ifc_wr_n, .ifc_addr, .ifc_data_o,
    .ifc_data_oe, .ifc_data_i, .service_request_n, .msg_load, .msg_byte, .got_addr);

  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask

  // ready drops after a take; bounded wait for its return
  task automatic wait_ready();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) chk(8'h00, 8'h01);
  endtask

  // request held until ready reads high after an edge; for bus cycles that is the edge that takes the command
  task automatic issue(input logic [1:0] op, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 500);
    cmd_valid <= 1'b0;
    if (n >= 500) chk(8'h00, 8'h01);
  endtask

  task automatic rd(input logic [1:0] op, input logic [10:0] a, input logic [7:0] exp);
    issue(op, a, 8'h00);
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < 200) begin
      @(posedge clk);
      lat++;
    end
    chk(rsp_data, exp);
    // address phase ends on the next free-running tick (1 to 20 cycles), then two full phases
    chk(8'((lat >= 2 * TICK_CYCLES + 2) && (lat <= 3 * TICK_CYCLES + 1)), 8'h01);
    wait_ready();
  endtask

  // expected latch contents worked out from the select pairs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (!a[1] && !a[6]) e_cal = d[7:4];
    if (!a[0] && !a[6]) e_lcb = d[3:0];
    if (!a[2] && !a[6]) e_vid = {2{d[3:0]}};
    if (!a[2] && !a[7]) e_xbw = {2{d[7:4]}};
    if (!a[1] && !a[7]) e_lbw = {2{d[7:4]}};
    if (!a[0] && !a[7]) e_xsb = d[3:0];
    issue(2'd1, {3'h0, a}, d);
    wait_ready();
    chk({cal_attenuator_steps, lc_stage_bypass}, {e_cal, e_lcb});
    chk(video_bandwidth_select, e_vid);
    chk(crystal_bandwidth_code, e_xbw);
    chk(lc_bandwidth_code, e_lbw);
    chk({4'h0, crystal_stage_bypass}, {4'h0, e_xsb});
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run is about a thousand cycles; this is ample
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end

  initial begin
    {reset_n, cmd_valid, cmd_op, cmd_addr, cmd_data, msg_load, msg_byte} = '0;
    {sys_reset_n, det_level_n} = 3'b111;
    {e_cal, e_lcb, e_xsb, e_vid, e_xbw, e_lbw} = '0;
    rom_ld_en = 1'b1;
    rom_ld_addr = 11'h000;
    rom_ld_data = 8'h5a;
    @(posedge clk);
    rom_ld_addr <= 11'h001;
    rom_ld_data <= 8'hc3;
    @(posedge clk);
    rom_ld_addr <= 11'h002;
    rom_ld_data <= 8'h96;
    @(posedge clk);
    rom_ld_en <= 1'b0;
    reset_n <= 1'b1;
    wait_ready();
    chk(got_addr, 8'h2b);
    chk({cal_attenuator_steps, crystal_stage_bypass}, 8'h00);
    for (int i = 0; i < 9; i++) wr(WA[i], WD[i]);
    rd(2'd0, 11'h000, 8'h5a);
    rd(2'd0, 11'h000, 8'hc3);
    // service request from the chip while idle
    msg_byte <= 8'h3c;
    msg_load <= 1'b1;
    @(posedge clk);
    msg_load <= 1'b0;
    lat = 0;
    while (msg_valid !== 1'b1 && lat < 300) begin
      @(posedge clk);
      lat++;
    end
    chk(msg_data, 8'h3c);
    chk(8'(lat < 300), 8'h01);
    wait_ready();
    rd(2'd0, 11'h000, 8'h96);
    // system reset line pulls the pointer back to zero
    sys_reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk({7'h0, cmd_ready}, 8'h00);
    sys_reset_n <= 1'b1;
    wait_ready();
    rd(2'd0, 11'h000, 8'h5a);
    det_level_n <= 2'b01;
    rd(2'd2, 11'h7f7, 8'hfd);
    det_level_n <= 2'b10;
    rd(2'd2, 11'h7f7, 8'hfe);
    // select line high: the buffer stays off and the bus idles
    rd(2'd2, 11'h7ff, BUS_IDLE);
    issue(2'd3, 11'h000, 8'h01);
    repeat (2) @(posedge clk);
    chk({6'h0, lamp_active, lamp_error}, 8'h01);
    issue(2'd3, 11'h000, 8'h02);
    repeat (2) @(posedge clk);
    chk({6'h0, lamp_active, lamp_error}, 8'h02);
    end_sim();
  end
endmodule
